//--- rtl/pdc_params.svh
// constants for the clock-synthesis divider configuration block
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// register addresses on the serial port
`define PDC_ADDR_REFO        15'h003c
`define PDC_ADDR_FBDIV_VP    15'h003d
`define PDC_ADDR_FBDIV_N     15'h003e
`define PDC_ADDR_OSC_BIAS    15'h003f
`define PDC_ADDR_PRE_EMPH    15'h0048

// reset values
`define PDC_RST_REFO         8'h01
`define PDC_RST_FBDIV_VP     8'h00
`define PDC_RST_FBDIV_N      8'h20
`define PDC_RST_OSC_BIAS     8'h4f
`define PDC_RST_PRE_EMPH     8'h00

// field positions
`define PDC_REFO_EN_BIT      0
`define PDC_P_MSB            3
`define PDC_P_LSB            2
`define PDC_V_MSB            1
`define PDC_V_LSB            0
`define PDC_N_MSB            5
`define PDC_N_LSB            0
`define PDC_BIAS_MSB         6
`define PDC_BIAS_LSB         0
`define PDC_PE_MSB           3
`define PDC_PE_LSB           0

// first divider ratios per code, zero means stopped
`define PDC_V_RATIO_C0       3'd5
`define PDC_V_RATIO_C1       3'd4
`define PDC_V_RATIO_C2       3'd3
// second divider ratios per code
`define PDC_P_RATIO_C0       3'd1
`define PDC_P_RATIO_C1       3'd2
`define PDC_P_RATIO_C2       3'd4
`define PDC_RATIO_STOP       3'd0

// serial frame: read flag, 15 address bits, 8 data bits
`define PDC_SPI_HDR_LAST     5'd15
`define PDC_SPI_DATA_FIRST   5'd16
`define PDC_SPI_FRAME_LAST   5'd23

`endif

//--- rtl/pdc_pkg.sv
// types for the clock-synthesis divider configuration block
`default_nettype none
package pdc_pkg;
`include "pdc_params.svh"

    typedef enum logic [1:0] {
        PDC_IDLE = 2'b00,
        PDC_HDR  = 2'b01,
        PDC_DATA = 2'b11,
        PDC_DONE = 2'b10
    } pdc_spi_state_t;

    typedef struct packed {
        pdc_spi_state_t state;
        logic           sclk_q;
        logic [4:0]     cnt;
        logic [22:0]    sh;
        logic           rd;
        logic [14:0]    addr;
        logic [7:0]     wdata;
        logic           wr;
        logic [7:0]     osh;
        logic           sdo;
        logic           sdo_oe_n;
    } pdc_spi_st_t;

    typedef struct packed {
        logic [7:0] refo;
        logic [7:0] fbdiv_vp;
        logic [7:0] fbdiv_n;
        logic [7:0] osc_bias;
        logic [7:0] pre_emph;
        logic [2:0] v_cnt;
        logic [1:0] p_cnt;
        logic [5:0] n_cnt;
        logic       samp_tick;
        logic       fb_tick;
        logic       ref_p;
        logic       ref_n;
    } pdc_core_st_t;

endpackage
`default_nettype wire

//--- rtl/pdc_reg_if.sv
// register access carrier between serial port and register file
`timescale 1ns/1ns
`default_nettype none
interface pdc_reg_if;
    logic        wr_stb;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;

    modport port (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- rtl/pdc_spi_port.sv
// serial register port: 24-bit frames, sclk sampled on the system clock
`timescale 1ns/1ns
`default_nettype none
`include "pdc_params.svh"
module pdc_spi_port
    import pdc_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  rstn,
    input  wire logic  spi_csn,
    input  wire logic  spi_sclk,
    input  wire logic  spi_sdi,
    output var  logic  spi_sdo,
    output var  logic  spi_sdo_oe_n,
    pdc_reg_if.port    rbus
);
    pdc_spi_st_t st_r;
    pdc_spi_st_t st_nxt;
    logic        rise;
    logic        fall;
    logic [15:0] hdr;

    assign rise = spi_sclk & ~st_r.sclk_q;
    assign fall = ~spi_sclk & st_r.sclk_q;
    assign hdr  = {st_r.sh[14:0], spi_sdi};

    always_comb begin
        st_nxt        = st_r;
        st_nxt.sclk_q = spi_sclk;
        st_nxt.wr     = 1'b0;
        if (spi_csn) begin
            // a frame cut short by chip select is dropped without a write
            st_nxt.state    = PDC_IDLE;
            st_nxt.cnt      = 5'd0;
            st_nxt.sdo_oe_n = 1'b1;
        end else begin
            case (st_r.state)
                PDC_IDLE: begin
                    st_nxt.state = PDC_HDR;
                    st_nxt.cnt   = 5'd0;
                    if (rise) begin
                        st_nxt.sh  = {st_r.sh[21:0], spi_sdi};
                        st_nxt.cnt = 5'd1;
                    end
                end
                PDC_HDR: begin
                    if (rise) begin
                        st_nxt.sh  = {st_r.sh[21:0], spi_sdi};
                        st_nxt.cnt = st_r.cnt + 5'd1;
                        if (st_r.cnt == `PDC_SPI_HDR_LAST) begin
                            st_nxt.state = PDC_DATA;
                            st_nxt.rd    = hdr[15];
                            st_nxt.addr  = hdr[14:0];
                        end
                    end
                end
                PDC_DATA: begin
                    if (fall && st_r.rd) begin
                        st_nxt.sdo_oe_n = 1'b0;
                        if (st_r.cnt == `PDC_SPI_DATA_FIRST) begin
                            st_nxt.sdo = rbus.rdata[7];
                            st_nxt.osh = {rbus.rdata[6:0], 1'b0};
                        end else begin
                            st_nxt.sdo = st_r.osh[7];
                            st_nxt.osh = {st_r.osh[6:0], 1'b0};
                        end
                    end
                    if (rise) begin
                        st_nxt.sh  = {st_r.sh[21:0], spi_sdi};
                        st_nxt.cnt = st_r.cnt + 5'd1;
                        if (st_r.cnt == `PDC_SPI_FRAME_LAST) begin
                            st_nxt.state = PDC_DONE;
                            st_nxt.wdata = {st_r.sh[6:0], spi_sdi};
                            st_nxt.wr    = ~st_r.rd;
                        end
                    end
                end
                default: begin
                    // extra clocks after a full frame are ignored
                    st_nxt.state = PDC_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{state: PDC_IDLE, sdo_oe_n: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rbus.wr_stb   = st_r.wr;
    assign rbus.addr     = st_r.addr;
    assign rbus.wdata    = st_r.wdata;
    assign spi_sdo       = st_r.sdo;
    assign spi_sdo_oe_n  = st_r.sdo_oe_n;
endmodule
`default_nettype wire

//--- rtl/pdc_clk_synth_cfg.sv
// clock-synthesis divider configuration registers with divider model
//
// Notes on behaviour
// - enable bit drives reference output while loop enabled
// - enable bit resets to one, output runs immediately
// - second divider: codes 0,1,2 give 1,2,4
// - first divider: codes 0,1,2 give 5,4,3
// - third divider makes feedback clock from sampling clock
// - one pre-emphasis code shared by all lanes
`timescale 1ns/1ns
`default_nettype none
`include "pdc_params.svh"
module pdc_clk_synth_cfg
    import pdc_pkg::*;
#(
    parameter int LANES = 8
) (
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              spi_csn,
    input  wire logic              spi_sclk,
    input  wire logic              spi_sdi,
    output var  logic              spi_sdo,
    output var  logic              spi_sdo_oe_n,
    input  wire logic              synth_loop_enable,
    input  wire logic              synth_loop_reset,
    output var  logic              ref_clock_output_pair_p,
    output var  logic              ref_clock_output_pair_n,
    output var  logic              samp_clock_tick,
    output var  logic              feedback_clock_tick,
    output var  logic [6:0]        oscillator_bias_level,
    output var  logic [LANES*4-1:0] lane_pre_emphasis_code
);
    localparam int PE_W = `PDC_PE_MSB - `PDC_PE_LSB + 1;

    // the lane bus carries four bits per lane, so the code field must match it
    generate
        if (LANES < 1 || LANES > 8) begin : g_lane_check
            $error("pdc_clk_synth_cfg: LANES must be 1 to 8");
        end
        if (PE_W != 4) begin : g_pe_check
            $error("pdc_clk_synth_cfg: pre-emphasis field must be 4 bits");
        end
    endgenerate

    pdc_core_st_t st_r;
    pdc_core_st_t st_nxt;
    pdc_reg_if    rbus ();

    logic [2:0] v_ratio;
    logic [2:0] p_ratio;
    logic [5:0] n_ratio;
    logic       loop_hold;
    logic       v_tick;
    logic       p_tick;
    logic       ref_on;
    logic [4:0] reg_sel;

    pdc_spi_port u_spi (
        .clock        (clock),
        .rstn         (rstn),
        .spi_csn      (spi_csn),
        .spi_sclk     (spi_sclk),
        .spi_sdi      (spi_sdi),
        .spi_sdo      (spi_sdo),
        .spi_sdo_oe_n (spi_sdo_oe_n),
        .rbus         (rbus.port)
    );

    function automatic logic [2:0] pdc_v_ratio(input logic [1:0] code);
        case (code)
            2'h0:    pdc_v_ratio = `PDC_V_RATIO_C0;
            2'h1:    pdc_v_ratio = `PDC_V_RATIO_C1;
            2'h2:    pdc_v_ratio = `PDC_V_RATIO_C2;
            default: pdc_v_ratio = `PDC_RATIO_STOP;
        endcase
    endfunction

    function automatic logic [2:0] pdc_p_ratio(input logic [1:0] code);
        case (code)
            2'h0:    pdc_p_ratio = `PDC_P_RATIO_C0;
            2'h1:    pdc_p_ratio = `PDC_P_RATIO_C1;
            2'h2:    pdc_p_ratio = `PDC_P_RATIO_C2;
            default: pdc_p_ratio = `PDC_RATIO_STOP;
        endcase
    endfunction

    // one-hot register select, shared so reads and writes can never decode apart
    function automatic logic [4:0] pdc_reg_sel(input logic [14:0] addr);
        if (addr == `PDC_ADDR_REFO) begin
            pdc_reg_sel = 5'h01;
        end else if (addr == `PDC_ADDR_FBDIV_VP) begin
            pdc_reg_sel = 5'h02;
        end else if (addr == `PDC_ADDR_FBDIV_N) begin
            pdc_reg_sel = 5'h04;
        end else if (addr == `PDC_ADDR_OSC_BIAS) begin
            pdc_reg_sel = 5'h08;
        end else if (addr == `PDC_ADDR_PRE_EMPH) begin
            pdc_reg_sel = 5'h10;
        end else begin
            pdc_reg_sel = 5'h00;
        end
    endfunction

    // a counter wraps on its last count; a stopped ratio of zero never wraps
    function automatic logic pdc_wrap(input logic [5:0] cnt, input logic [5:0] ratio);
        pdc_wrap = (ratio != 6'h00) && (cnt == ratio - 6'h01);
    endfunction

    assign reg_sel = pdc_reg_sel(rbus.addr);

    // reads return the whole stored byte, reserved bits included
    always_comb begin
        if (reg_sel[0]) begin
            rbus.rdata = st_r.refo;
        end else if (reg_sel[1]) begin
            rbus.rdata = st_r.fbdiv_vp;
        end else if (reg_sel[2]) begin
            rbus.rdata = st_r.fbdiv_n;
        end else if (reg_sel[3]) begin
            rbus.rdata = st_r.osc_bias;
        end else if (reg_sel[4]) begin
            rbus.rdata = st_r.pre_emph;
        end else begin
            rbus.rdata = 8'h00;
        end
    end

    assign v_ratio   = pdc_v_ratio(st_r.fbdiv_vp[`PDC_V_MSB:`PDC_V_LSB]);
    assign p_ratio   = pdc_p_ratio(st_r.fbdiv_vp[`PDC_P_MSB:`PDC_P_LSB]);
    assign n_ratio   = st_r.fbdiv_n[`PDC_N_MSB:`PDC_N_LSB];
    // the model stays parked while reset is held, so mid-change ratios never run
    assign loop_hold = synth_loop_reset | ~synth_loop_enable;
    assign v_tick    = pdc_wrap({3'h0, st_r.v_cnt}, {3'h0, v_ratio});
    assign p_tick    = v_tick && pdc_wrap({4'h0, st_r.p_cnt}, {3'h0, p_ratio});
    assign ref_on    = st_r.refo[`PDC_REFO_EN_BIT] & synth_loop_enable;

    always_comb begin
        st_nxt = st_r;
        // reserved bits are stored as written; keeping them clean is up to software
        if (rbus.wr_stb) begin
            if (reg_sel[0]) begin
                st_nxt.refo = rbus.wdata;
            end else if (reg_sel[1]) begin
                st_nxt.fbdiv_vp = rbus.wdata;
            end else if (reg_sel[2]) begin
                st_nxt.fbdiv_n = rbus.wdata;
            end else if (reg_sel[3]) begin
                st_nxt.osc_bias = rbus.wdata;
            end else if (reg_sel[4]) begin
                st_nxt.pre_emph = rbus.wdata;
            end
        end

        // divider chain: first counts clocks, second counts its wraps, third counts sampling ticks
        st_nxt.samp_tick = 1'b0;
        st_nxt.fb_tick   = 1'b0;
        if (loop_hold) begin
            st_nxt.v_cnt = 3'd0;
            st_nxt.p_cnt = 2'd0;
            st_nxt.n_cnt = 6'd0;
        end else if (v_tick) begin
            st_nxt.v_cnt = 3'd0;
            if (p_tick) begin
                st_nxt.p_cnt     = 2'd0;
                st_nxt.samp_tick = 1'b1;
                // ratio zero is unsupported and yields no feedback clock
                if (pdc_wrap(st_r.n_cnt, n_ratio)) begin
                    st_nxt.n_cnt   = 6'd0;
                    st_nxt.fb_tick = 1'b1;
                end else if (n_ratio != 6'd0) begin
                    st_nxt.n_cnt = st_r.n_cnt + 6'd1;
                end
            end else begin
                st_nxt.p_cnt = st_r.p_cnt + 2'd1;
            end
        end else if (v_ratio != `PDC_RATIO_STOP) begin
            st_nxt.v_cnt = st_r.v_cnt + 3'd1;
        end

        // differential pair toggles at half the clock; both legs low when off
        if (ref_on) begin
            st_nxt.ref_p = ~st_r.ref_p;
            st_nxt.ref_n = st_r.ref_p;
        end else begin
            st_nxt.ref_p = 1'b0;
            st_nxt.ref_n = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // enable bit set at reset lets the loop enable alone start the reference output
            st_r <= '{refo:     `PDC_RST_REFO,
                      fbdiv_vp: `PDC_RST_FBDIV_VP,
                      fbdiv_n:  `PDC_RST_FBDIV_N,
                      osc_bias: `PDC_RST_OSC_BIAS,
                      pre_emph: `PDC_RST_PRE_EMPH,
                      default:  '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // every output is a register field, so no decode glitch reaches a pin
    assign ref_clock_output_pair_p = st_r.ref_p;
    assign ref_clock_output_pair_n = st_r.ref_n;
    assign samp_clock_tick         = st_r.samp_tick;
    assign feedback_clock_tick     = st_r.fb_tick;
    assign oscillator_bias_level   = st_r.osc_bias[`PDC_BIAS_MSB:`PDC_BIAS_LSB];

    // one stored code fanned out, so no lane can ever disagree with another
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            assign lane_pre_emphasis_code[gi*PE_W +: PE_W] = st_r.pre_emph[`PDC_PE_MSB:`PDC_PE_LSB];
        end
    endgenerate
endmodule
`default_nettype wire

//--- testbench/pdc_clk_synth_cfg_sva.sv
// concurrent checks on the ports of the divider configuration block
`timescale 1ns/1ns
`default_nettype none
module pdc_clk_synth_cfg_sva
#(
    parameter int LANES = 8
) (
    input wire logic               clock,
    input wire logic               rstn,
    input wire logic               synth_loop_enable,
    input wire logic               synth_loop_reset,
    input wire logic               ref_clock_output_pair_p,
    input wire logic               ref_clock_output_pair_n,
    input wire logic               samp_clock_tick,
    input wire logic               feedback_clock_tick,
    input wire logic [LANES*4-1:0] lane_pre_emphasis_code
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_loop_idle;
        synth_loop_reset || !synth_loop_enable;
    endsequence
    sequence s_ref_quiet;
        !ref_clock_output_pair_p && !ref_clock_output_pair_n;
    endsequence
    sequence s_samp_gap;
        !samp_clock_tick [*2];
    endsequence

    AST_REF_OFF: assert property (!synth_loop_enable |=> s_ref_quiet)
        else $error("reference pair active with loop disabled");
    AST_REF_PAIR: assert property (ref_clock_output_pair_p |-> !ref_clock_output_pair_n)
        else $error("reference pair legs not opposite");
    AST_REF_START: assert property ($rose(rstn) && synth_loop_enable && !synth_loop_reset |=> ref_clock_output_pair_p)
        else $error("reference output did not start after reset");
    AST_SAMP_GAP: assert property (samp_clock_tick |=> s_samp_gap)
        else $error("sampling ticks closer than the smallest ratio");
    AST_SAMP_QUIET: assert property (s_loop_idle |=> !samp_clock_tick)
        else $error("sampling tick while loop held idle");
    AST_FB_ALIGN: assert property (feedback_clock_tick |-> samp_clock_tick)
        else $error("feedback tick without sampling tick");
    AST_FB_GAP: assert property (feedback_clock_tick |=> !feedback_clock_tick [*2])
        else $error("feedback ticks too close");
    AST_PE_LANES: assert property (lane_pre_emphasis_code == {LANES{lane_pre_emphasis_code[3:0]}})
        else $error("lanes carry different pre-emphasis codes");
endmodule

bind pdc_clk_synth_cfg pdc_clk_synth_cfg_sva #(.LANES(LANES)) u_sva (
    .clock                   (clock),
    .rstn                    (rstn),
    .synth_loop_enable       (synth_loop_enable),
    .synth_loop_reset        (synth_loop_reset),
    .ref_clock_output_pair_p (ref_clock_output_pair_p),
    .ref_clock_output_pair_n (ref_clock_output_pair_n),
    .samp_clock_tick         (samp_clock_tick),
    .feedback_clock_tick     (feedback_clock_tick),
    .lane_pre_emphasis_code  (lane_pre_emphasis_code)
);
`default_nettype wire

//--- testbench/pdc_clk_synth_cfg_tb_top.sv
// self-checking bench for the divider configuration block
`timescale 1ns/1ns
`default_nettype none
module pdc_clk_synth_cfg_tb_top;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        spi_csn = 1'b1;
    logic        spi_sclk = 1'b0;
    logic        spi_sdi = 1'b0;
    logic        synth_loop_enable = 1'b1;
    logic        synth_loop_reset = 1'b0;
    logic        spi_sdo, spi_sdo_oe_n, ref_p, ref_n, samp_tick, fb_tick, p0;
    logic [6:0]  bias;
    logic [31:0] pe_code;
    logic [7:0]  rd;
    logic        oe_low;
    int          miscompares = 0;
    int          checked = 0;
    int          n;

    always #5 clock = ~clock;

    pdc_clk_synth_cfg dut (
        .clock                   (clock),
        .rstn                    (rstn),
        .spi_csn                 (spi_csn),
        .spi_sclk                (spi_sclk),
        .spi_sdi                 (spi_sdi),
        .spi_sdo                 (spi_sdo),
        .spi_sdo_oe_n            (spi_sdo_oe_n),
        .synth_loop_enable       (synth_loop_enable),
        .synth_loop_reset        (synth_loop_reset),
        .ref_clock_output_pair_p (ref_p),
        .ref_clock_output_pair_n (ref_n),
        .samp_clock_tick         (samp_tick),
        .feedback_clock_tick     (fb_tick),
        .oscillator_bias_level   (bias),
        .lane_pre_emphasis_code  (pe_code)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // sclk phases of three clocks keep the port's edge detector comfortably fed
    task automatic spi(input logic rnw, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {rnw, a, d};
        rd = 8'h00;
        oe_low = 1'b1;
        @(negedge clock);
        spi_csn = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_sdi = f[i];
            repeat (3) @(negedge clock);
            if (i < 8) begin
                rd[i] = spi_sdo;
                oe_low = oe_low & ~spi_sdo_oe_n;
            end
            spi_sclk = 1'b1;
            repeat (3) @(negedge clock);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge clock);
        spi_csn = 1'b1;
        repeat (3) @(negedge clock);
    endtask

    task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
        spi(1'b1, a, 8'h00);
        chk(rd, exp);
        chk(oe_low, 1'b1);
        chk(spi_sdo_oe_n, 1'b1);
    endtask

    task automatic wait_tick(input bit fb);
        int k;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while ((fb ? fb_tick : samp_tick) !== 1'b1 && k < 2000);
        n = k;
        if ((fb ? fb_tick : samp_tick) !== 1'b1) begin
            miscompares++;
            $display("BAD t=%0t tick never came", $time);
            finish_test();
        end
    endtask

    task automatic test_end(input string s);
        $display("test done: %s", s);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        wait_tick(1'b1);
        wait_tick(1'b1);
        chk(n, 160);
        rdchk(15'h003c, 8'h01);
        rdchk(15'h003d, 8'h00);
        rdchk(15'h003e, 8'h20);
        rdchk(15'h003f, 8'h4f);
        rdchk(15'h0048, 8'h00);
        rdchk(15'h0040, 8'h00);
        test_end("reset values");
        p0 = ref_p;
        @(negedge clock);
        chk({ref_p, ref_n}, {~p0, p0});
        synth_loop_enable = 1'b0;
        repeat (2) @(negedge clock);
        chk({ref_p, ref_n}, 2'b00);
        synth_loop_enable = 1'b1;
        spi(1'b0, 15'h003c, 8'h00);
        chk({ref_p, ref_n}, 2'b00);
        spi(1'b0, 15'h003c, 8'h01);
        chk(ref_p ^ ref_n, 1'b1);
        test_end("reference output");
        spi(1'b0, 15'h003f, 8'h4a);
        chk(bias, 7'h4a);
        spi(1'b0, 15'h0048, 8'h0b);
        chk(pe_code, {8{4'hb}});
        rdchk(15'h0048, 8'h0b);
        test_end("bias and pre-emphasis");
        synth_loop_reset = 1'b1;
        spi(1'b0, 15'h003e, 8'h03);
        for (int v = 0; v < 3; v++) begin
            for (int p = 0; p < 3; p++) begin
                synth_loop_reset = 1'b1;
                spi(1'b0, 15'h003d, 8'(p * 4 + v));
                synth_loop_reset = 1'b0;
                wait_tick(1'b0);
                wait_tick(1'b0);
                chk(n, (5 - v) * (1 << p));
                wait_tick(1'b1);
                wait_tick(1'b1);
                chk(n, (5 - v) * (1 << p) * 3);
            end
        end
        test_end("divider ratios");
        finish_test();
    end
endmodule
`default_nettype wire
